/* rtl/fbws_pkg.sv */
// package: constants and types for the full-bridge steering stage
package fbws_pkg;
	localparam logic [2:0] MODE_FWD = 3'h2;
	localparam logic [2:0] MODE_REV = 3'h3;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam int DB_W = 8;
	localparam logic [DB_W-1:0] DB_DEFAULT = 8'h04;
	localparam logic DIR_RESET = 1'b0;

	typedef enum {
		FBWS_OFF,
		FBWS_RUN,
		FBWS_WAIT_EDGE,
		FBWS_DEADBAND
	} fbws_state_t;

	typedef struct packed {
		logic a;
		logic b;
		logic c;
		logic d;
	} fbws_bridge_t;
endpackage

/* rtl/fbws_steer.sv */
// full-bridge steering of a modulated signal onto four bridge outputs
// Overview of operation
// - forward mode 010: A active, D modulated, B and C inactive.
// - reverse mode 011: C active, B modulated, A and D inactive.
// - only the mode field sets direction; changing it starts a switch.
// - new direction applies at next rising edge of modulated input.
// - at the switch A and C exchange their steady levels.
// - at the switch old modulated leg goes inactive, other leg modulates.
// - new modulated leg stays inactive until direction dead band elapses.
`timescale 1ns/10ps
module fbws_steer (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [2:0] waveform_control_0,
	input wire logic [fbws_pkg::DB_W-1:0] dir_deadband,
	input wire logic mod_in,
	output fbws_pkg::fbws_bridge_t bridge_out,
	output logic switching
);
	logic mod_s1_reg;
	logic mod_s2_reg;
	logic mod_d_reg;
	logic [2:0] mode_s1_reg;
	logic [2:0] mode_reg;
	logic rise;
	logic is_fb;
	logic want_rev;
	logic dir_reg;
	logic mod_en_reg;
	logic [fbws_pkg::DB_W-1:0] db_cnt_reg;
	fbws_pkg::fbws_state_t state_reg;
	fbws_pkg::fbws_bridge_t bridge_next;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mod_s1_reg <= 1'b0;
			mod_s2_reg <= 1'b0;
			mod_d_reg <= 1'b0;
			mode_s1_reg <= fbws_pkg::MODE_RESET;
			mode_reg <= fbws_pkg::MODE_RESET;
		end else begin
			mod_s1_reg <= mod_in;
			mod_s2_reg <= mod_s1_reg;
			mod_d_reg <= mod_s2_reg;
			mode_s1_reg <= waveform_control_0;
			mode_reg <= mode_s1_reg;
		end
	end

	assign rise = mod_s2_reg & ~mod_d_reg;
	assign is_fb = (mode_reg == fbws_pkg::MODE_FWD) ||
		(mode_reg == fbws_pkg::MODE_REV);
	assign want_rev = (mode_reg == fbws_pkg::MODE_REV);

	// direction sequencer
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg <= fbws_pkg::FBWS_OFF;
			dir_reg <= fbws_pkg::DIR_RESET;
			mod_en_reg <= 1'b0;
			db_cnt_reg <= '0;
		end else begin
			unique case (state_reg)
				fbws_pkg::FBWS_OFF: begin
					mod_en_reg <= 1'b0;
					if (is_fb) begin
						dir_reg <= want_rev;
						mod_en_reg <= 1'b1;
						state_reg <= fbws_pkg::FBWS_RUN;
					end
				end
				fbws_pkg::FBWS_RUN: begin
					if (!is_fb) begin
						state_reg <= fbws_pkg::FBWS_OFF;
						mod_en_reg <= 1'b0;
					end else if (want_rev != dir_reg) begin
						state_reg <= fbws_pkg::FBWS_WAIT_EDGE;
					end
				end
				fbws_pkg::FBWS_WAIT_EDGE: begin
					if (!is_fb) begin
						state_reg <= fbws_pkg::FBWS_OFF;
						mod_en_reg <= 1'b0;
					end else if (want_rev == dir_reg) begin
						state_reg <= fbws_pkg::FBWS_RUN;
					end else if (rise) begin
						dir_reg <= want_rev;
						mod_en_reg <= 1'b0;
						db_cnt_reg <= dir_deadband;
						state_reg <= fbws_pkg::FBWS_DEADBAND;
					end
				end
				fbws_pkg::FBWS_DEADBAND: begin
					if (!is_fb) begin
						state_reg <= fbws_pkg::FBWS_OFF;
					end else if (db_cnt_reg == '0) begin
						mod_en_reg <= 1'b1;
						state_reg <= fbws_pkg::FBWS_RUN;
					end else begin
						db_cnt_reg <= db_cnt_reg - 1'b1;
					end
				end
			endcase
		end
	end

	always_comb begin
		bridge_next = '0;
		if (state_reg != fbws_pkg::FBWS_OFF) begin
			if (!dir_reg) begin
				bridge_next.a = 1'b1;
				bridge_next.d = mod_s2_reg & mod_en_reg;
			end else begin
				bridge_next.c = 1'b1;
				bridge_next.b = mod_s2_reg & mod_en_reg;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bridge_out <= '0;
			switching <= 1'b0;
		end else begin
			bridge_out <= bridge_next;
			switching <= (state_reg == fbws_pkg::FBWS_WAIT_EDGE) ||
				(state_reg == fbws_pkg::FBWS_DEADBAND);
		end
	end

	// switch instant: pending change meets a modulated rising edge
	sequence swap_s;
		state_reg == fbws_pkg::FBWS_WAIT_EDGE && rise && is_fb &&
		want_rev != dir_reg;
	endsequence
	sequence back_fwd_s;
		swap_s ##0 dir_reg;
	endsequence
	sequence sw_start_s;
		state_reg == fbws_pkg::FBWS_RUN && is_fb && want_rev != dir_reg;
	endsequence
	sequence db_done_s;
		state_reg == fbws_pkg::FBWS_DEADBAND && db_cnt_reg == '0 && is_fb;
	endsequence
	sequence fwd_mod_s;
		state_reg == fbws_pkg::FBWS_RUN && !dir_reg && mod_en_reg;
	endsequence
	sequence rev_mod_s;
		state_reg == fbws_pkg::FBWS_RUN && dir_reg && mod_en_reg;
	endsequence

	fwd_map_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == fbws_pkg::FBWS_RUN && !dir_reg) |=>
		(bridge_out.a && !bridge_out.b && !bridge_out.c))
		else $error("forward mapping wrong");
	fwd_mod_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		fwd_mod_s |=>
		(bridge_out.d == $past(mod_s2_reg)))
		else $error("forward leg not following modulation");
	rev_map_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == fbws_pkg::FBWS_RUN && dir_reg) |=>
		(bridge_out.c && !bridge_out.a && !bridge_out.d))
		else $error("reverse mapping wrong");
	rev_mod_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rev_mod_s |=>
		(bridge_out.b == $past(mod_s2_reg)))
		else $error("reverse leg not following modulation");
	start_sw_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		sw_start_s |=>
		(state_reg == fbws_pkg::FBWS_WAIT_EDGE))
		else $error("direction change not started");
	sw_flag_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		sw_start_s |=>
		##1 switching)
		else $error("pending switch not flagged");
	cancel_sw_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == fbws_pkg::FBWS_WAIT_EDGE && is_fb && want_rev == dir_reg)
		|=> (state_reg == fbws_pkg::FBWS_RUN && $stable(dir_reg)))
		else $error("withdrawn switch not cancelled");
	off_idle_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == fbws_pkg::FBWS_OFF) |=>
		(bridge_out == '0))
		else $error("outputs driven outside full-bridge");
	dir_hold_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == fbws_pkg::FBWS_WAIT_EDGE && !rise) |=>
		$stable(dir_reg))
		else $error("direction changed without edge");
	swap_levels_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		swap_s |=> ##1 (bridge_out.a == $past(bridge_out.c) &&
		bridge_out.c == $past(bridge_out.a)))
		else $error("steady legs not exchanged");
	leg_quiet_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		swap_s |=>
		##1 (!bridge_out.b && !bridge_out.d))
		else $error("legs not quiet after switch");
	db_load_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		swap_s |=> (state_reg == fbws_pkg::FBWS_DEADBAND &&
		db_cnt_reg == $past(dir_deadband) && !mod_en_reg))
		else $error("dead band not started at switch");
	db_block_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == fbws_pkg::FBWS_DEADBAND) |=>
		(!bridge_out.b && !bridge_out.d))
		else $error("modulation during dead band");
	db_count_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == fbws_pkg::FBWS_DEADBAND && is_fb && db_cnt_reg != '0)
		|=> (db_cnt_reg == $past(db_cnt_reg) - 8'h01))
		else $error("dead band count wrong");
	db_resume_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		db_done_s |=>
		(state_reg == fbws_pkg::FBWS_RUN && mod_en_reg))
		else $error("modulation not resumed after dead band");
	mirror_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		back_fwd_s |=>
		!dir_reg)
		else $error("reverse to forward not taken");
	mirror_out_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		back_fwd_s |=> ##1 (bridge_out.a && !bridge_out.b &&
		!bridge_out.c && !bridge_out.d))
		else $error("forward legs wrong after reverse");
endmodule // fbws_steer

/* test/fbws_bridge_model.sv */
// bridge switch model that flags shoot-through on either leg
`timescale 1ns/10ps
module fbws_bridge_model (
	input wire logic ref_clk,
	input wire fbws_pkg::fbws_bridge_t bridge_out,
	output logic fault
);
	logic fault_reg = 1'b0;
	always @(posedge ref_clk) begin
		if ((bridge_out.a && bridge_out.b) || (bridge_out.c && bridge_out.d))
			fault_reg <= 1'b1;
	end
	assign fault = fault_reg;
endmodule // fbws_bridge_model

/* test/test_full_bridge_waveform_steering.sv */
// testbench for the full-bridge steering stage
`timescale 1ns/10ps
module test_full_bridge_waveform_steering;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] mode = 3'h0;
	logic [fbws_pkg::DB_W-1:0] dead_band = fbws_pkg::DB_DEFAULT;
	logic mod_in = 1'b0;
	logic fault;
	logic switching;
	fbws_pkg::fbws_bridge_t bridge_out;
	int bad_count = 0;
	int checks_done = 0;
	always #2 ref_clk = ~ref_clk;
	fbws_steer i_fbws_steer (.ref_clk(ref_clk), .rst_n(rst_n),
		.waveform_control_0(mode), .dir_deadband(dead_band), .mod_in(mod_in),
		.bridge_out(bridge_out), .switching(switching));
	fbws_bridge_model i_fbws_bridge_model (.ref_clk(ref_clk),
		.bridge_out(bridge_out), .fault(fault));
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic conclude;
		if (bad_count == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic expect_out(input logic [3:0] exp, input logic sw);
		#1;
		checks_done++;
		if (bridge_out !== exp || switching !== sw || fault !== 1'b0) begin
			bad_count++;
			$display("ERROR bridge_out exp %h/%b seen %h/%b fault %b", exp, sw,
				bridge_out, switching, fault);
		end
	endtask
	// entry into forward from off, modulated leg high then low
	task automatic forward_entry;
		@(posedge ref_clk) mode <= fbws_pkg::MODE_FWD;
		step(6);
		@(posedge ref_clk) mod_in <= 1'b1;
		step(4);
		expect_out(4'h9, 1'b0);
		@(posedge ref_clk) mod_in <= 1'b0;
		step(4);
		expect_out(4'h8, 1'b0);
	endtask
	// direction change: hold until edge, swap, dead band, then modulate
	task automatic direction_change(input logic [2:0] to,
		input logic [fbws_pkg::DB_W-1:0] db, input logic [3:0] hold,
		input logic [3:0] mid, input logic [3:0] fin);
		@(posedge ref_clk) begin
			mode <= to;
			dead_band <= db;
		end
		step(10);
		expect_out(hold, 1'b1);
		@(posedge ref_clk) mod_in <= 1'b1;
		step(4);
		expect_out(mid, 1'b1);
		step(db);
		expect_out(mid, 1'b1);
		step(1);
		expect_out(fin, 1'b0);
		step(20);
		expect_out(fin, 1'b0);
		@(posedge ref_clk) mod_in <= 1'b0;
		step(4);
		expect_out(mid, 1'b0);
	endtask
	// a reversal withdrawn before any modulated edge leaves forward running
	task automatic cancel_switch;
		@(posedge ref_clk) mode <= fbws_pkg::MODE_REV;
		step(6);
		expect_out(4'h8, 1'b1);
		@(posedge ref_clk) mode <= fbws_pkg::MODE_FWD;
		step(6);
		expect_out(4'h8, 1'b0);
		@(posedge ref_clk) mod_in <= 1'b1;
		step(4);
		expect_out(4'h9, 1'b0);
		@(posedge ref_clk) mod_in <= 1'b0;
		step(4);
		expect_out(4'h8, 1'b0);
	endtask
	// reset taken while a reversal is pending clears all legs
	task automatic reset_pending;
		@(posedge ref_clk) mode <= fbws_pkg::MODE_REV;
		step(6);
		expect_out(4'h8, 1'b1);
		@(posedge ref_clk) rst_n <= 1'b0;
		step(2);
		expect_out(4'h0, 1'b0);
		@(posedge ref_clk) rst_n <= 1'b1;
		step(1);
		expect_out(4'h0, 1'b0);
		step(6);
		expect_out(4'h2, 1'b0);
	endtask
	initial begin
		step(1000);
		bad_count++;
		conclude();
	end
	initial begin
		step(4);
		rst_n <= 1'b1;
		forward_entry();
		direction_change(fbws_pkg::MODE_REV, 8'h08, 4'h8, 4'h2, 4'h6);
		direction_change(fbws_pkg::MODE_FWD, fbws_pkg::DB_DEFAULT, 4'h2,
			4'h8, 4'h9);
		cancel_switch();
		reset_pending();
		@(posedge ref_clk) mode <= 3'h1;
		step(6);
		expect_out(4'h0, 1'b0);
		@(posedge ref_clk) mode <= fbws_pkg::MODE_RESET;
		step(6);
		expect_out(4'h0, 1'b0);
		conclude();
	end
endmodule // test_full_bridge_waveform_steering
